// file: inc/isr_pkg.sv
// package for the serial ram link: address pattern, sizes, timing counts
// assumes a 20 MHz system clock on both ends
package isr_pkg;
    // ==========================================
    // sizes and address
    localparam int ISR_DEPTH = 128;
    localparam int ISR_AW = 7;
    localparam logic [3:0] ISR_GROUP = 4'ha;
    localparam logic ISR_DIR_READ = 1'h1;
    // ==========================================
    // timing
    localparam int ISR_CLK_HZ = 20000000;
    localparam int ISR_SCL_HZ = 100000;
    // half period of the generated serial clock, rounded up so the rate stays at or below max
    localparam int ISR_HALF_CYC = (ISR_CLK_HZ + 2 * ISR_SCL_HZ - 1) / (2 * ISR_SCL_HZ);
    // ==========================================
    // host commands
    typedef enum logic [1:0] {
        ISR_CMD_START = 2'h0,
        ISR_CMD_WRITE = 2'h1,
        ISR_CMD_READ = 2'h2,
        ISR_CMD_STOP = 2'h3
    } isr_cmd_e;
endpackage : isr_pkg

// file: inc/isr_if.sv
// two wire link between the ram end and the master end
// assumes pull-ups: a line is low only while some end drives it low
interface isr_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire logic scl;
    wire logic sda;
    // ==========================================
    // wired and of open drain drivers
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport ram (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe,
                    output sda_m_o, output sda_m_oe);
endinterface : isr_if

// file: hw/isr_sync.sv
// two flip-flop synchroniser for one bus line
// assumes the line is asynchronous to clk; idles high
module isr_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : isr_sync

// file: hw/isr_ram.sv
// ram end of the serial link: 128 x 8 store behind a two wire slave
// assumes the master drives scl; lines arrive asynchronously and are synchronised here
// ==========================================
// Overview of operation
// - store of 128 bytes, read and write
// - word address advances after each byte
// - three strap pins give low address
// - upper address 1010, others ignored
// - one bit per clock, change while low
// - start: data falls while clock high
// - stop: data rises while clock high
// - master starts only on idle bus
// - ninth clock acknowledges, transmitter releases data
// - receiver ack holds data low throughout
// - master acks all but final read byte
// - no ack on read: release data
// - unlimited bytes, address keeps advancing
// - first byte after start is address
// - fast mode clock at most 100kHz
// - slow mode 2kHz, 105us low, 365us high; not provided, isr_master runs only at 100kHz
// - test plus straps high saves power
// - reset returns bus logic to idle
module isr_ram (
    input wire logic clk,
    input wire logic rst,
    isr_if.ram bus,
    input wire logic slave_addr_strap_bit0,
    input wire logic slave_addr_strap_bit1,
    input wire logic slave_addr_strap_bit2,
    input wire logic test_pin,
    output logic power_save,
    output logic [isr_pkg::ISR_AW-1:0] word_addr
);
    import isr_pkg::*;

    typedef enum logic [2:0] {
        ISR_S_IDLE = 3'h0,
        ISR_S_ADDR = 3'h1,
        ISR_S_WADR = 3'h3,
        ISR_S_WDAT = 3'h2,
        ISR_S_RDAT = 3'h6
    } isr_state_e;

    // ==========================================
    // line sampling and edges
    logic scl_s, sda_s, scl_d, sda_d;
    isr_sync u_scl (.clk(clk), .rst(rst), .din(bus.scl), .dout(scl_s));
    isr_sync u_sda (.clk(clk), .rst(rst), .din(bus.sda), .dout(sda_s));
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;

    // ==========================================
    // strap and test pins: two flops each before any logic
    logic [3:0] pin_raw, pin_s;
    logic [1:0] pin_age;
    assign pin_raw = {test_pin, slave_addr_strap_bit2, slave_addr_strap_bit1,
                      slave_addr_strap_bit0};
    for (genvar i = 0; i < 4; i++) begin : g_pin
        isr_sync u_pin (
            .clk(clk),
            .rst(rst),
            .din(pin_raw[i]),
            .dout(pin_s[i])
        );
    end

    // ==========================================
    // power saving: mirrors pins, no state lost
    // sync flops reset high, so the flag waits two edges for real pin values
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_age <= 2'h0;
            power_save <= 1'b0;
        end else begin
            pin_age <= {pin_age[0], 1'b1};
            power_save <= pin_age[1] && (&pin_s);
        end
    end

    // ==========================================
    // framing
    isr_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg, tx;
    logic ack_phase, drive_ack, drive_data, rd_nack;
    logic [7:0] mem [ISR_DEPTH];
    logic [6:0] my_addr;
    assign my_addr = {ISR_GROUP, pin_s[2:0]};
    logic byte_done;
    assign byte_done = scl_fall && bit_cnt == 4'h8 && !ack_phase;

    // bit counter and receive shifter; samples on rising clock only
    always_ff @(posedge clk) begin
        if (rst || start_det || stop_det) begin
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            shreg <= 8'h00;
        end else if (scl_rise && !ack_phase) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (byte_done) begin
            ack_phase <= 1'b1;
        end else if (scl_fall && ack_phase) begin
            ack_phase <= 1'b0;
            bit_cnt <= 4'h0;
        end
    end

    // state, address match and acknowledge
    always_ff @(posedge clk) begin
        if (rst || stop_det) begin
            state <= ISR_S_IDLE;
            drive_ack <= 1'b0;
            rd_nack <= 1'b0;
        end else if (start_det) begin
            state <= ISR_S_ADDR;
            drive_ack <= 1'b0;
            rd_nack <= 1'b0;
        end else begin
            if (byte_done) begin
                case (state)
                    ISR_S_ADDR: begin
                        if (shreg[7:1] == my_addr) begin
                            drive_ack <= !shreg[0];
                            state <= shreg[0] == ISR_DIR_READ ? ISR_S_RDAT : ISR_S_WADR;
                            if (shreg[0] == ISR_DIR_READ) begin
                                drive_ack <= 1'b1;
                            end
                        end else begin
                            state <= ISR_S_IDLE;
                        end
                    end
                    ISR_S_WADR: begin
                        drive_ack <= 1'b1;
                        state <= ISR_S_WDAT;
                    end
                    ISR_S_WDAT: begin
                        drive_ack <= 1'b1;
                    end
                    ISR_S_RDAT: begin
                        drive_ack <= 1'b0; // master owns this slot
                    end
                    default: state <= ISR_S_IDLE;
                endcase
            end
            if (scl_rise && ack_phase && state == ISR_S_RDAT && !drive_ack) begin
                rd_nack <= sda_s;
            end
            if (scl_fall && ack_phase) begin
                drive_ack <= 1'b0; // held through whole high phase
                if (state == ISR_S_RDAT && rd_nack) begin
                    state <= ISR_S_IDLE;
                end
            end
        end
    end

    // read data loads at the falling edge that opens each read byte
    always_ff @(posedge clk) begin
        if (rst) begin
            tx <= 8'h00;
            drive_data <= 1'b0;
        end else if (start_det || stop_det) begin
            drive_data <= 1'b0;
        end else if (scl_fall && ack_phase && state == ISR_S_RDAT && !rd_nack
                     && !(sda_s && !drive_ack)) begin
            tx <= mem[word_addr];
            drive_data <= 1'b1;
        end else if (scl_fall && !ack_phase && drive_data) begin
            if (bit_cnt == 4'h8) begin
                drive_data <= 1'b0;
            end else begin
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // ==========================================
    // word address and store
    logic load_addr, step_addr, store_wr;
    assign load_addr = byte_done && state == ISR_S_WADR;
    assign store_wr = byte_done && state == ISR_S_WDAT;
    assign step_addr = store_wr || (byte_done && state == ISR_S_RDAT);

    // only seven bits kept, so stepping past the top wraps to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            word_addr <= 7'h00;
        end else if (load_addr) begin
            word_addr <= shreg[ISR_AW-1:0];
        end else if (step_addr) begin
            word_addr <= word_addr + 7'h01;
        end
    end

    // no reset: contents are undefined until written
    always_ff @(posedge clk) begin
        if (!rst && store_wr) begin
            mem[word_addr] <= shreg;
        end
    end

    // open drain: only ever pull low
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = (drive_ack && ack_phase) || (drive_data && !tx[7]);
endmodule : isr_ram

// file: hw/isr_master.sv
// master end: turns user commands into start, byte, stop on the two wires
// assumes one command at a time; cmd_ready marks when another may be given
module isr_master (
    input wire logic clk,
    input wire logic rst,
    isr_if.master bus,
    input wire logic cmd_valid,
    input wire isr_pkg::isr_cmd_e cmd,
    input wire logic [7:0] wdata,
    input wire logic rd_ack,
    output logic cmd_ready,
    output logic done,
    output logic [7:0] rdata,
    output logic ack_seen
);
    import isr_pkg::*;
    typedef enum logic [1:0] {
        ISR_M_IDLE = 2'h0,
        ISR_M_BUSY = 2'h1
    } isr_mstate_e;

    logic scl_s, sda_s;
    isr_sync u_scl (.clk(clk), .rst(rst), .din(bus.scl), .dout(scl_s));
    isr_sync u_sda (.clk(clk), .rst(rst), .din(bus.sda), .dout(sda_s));

    // ==========================================
    // sequencer: each step is one half period at 100kHz
    isr_mstate_e state;
    isr_cmd_e op;
    logic [15:0] tick;
    logic [5:0] step;
    logic [7:0] sh;
    logic scl_q, sda_q, sda_next, sda_pend;
    logic [5:0] last_step;
    assign last_step = (op == ISR_CMD_START || op == ISR_CMD_STOP) ? 6'h02 : 6'h12;
    assign cmd_ready = state == ISR_M_IDLE;
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ISR_M_IDLE;
            op <= ISR_CMD_STOP;
            tick <= 16'h0000;
            step <= 6'h00;
            sh <= 8'h00;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_next <= 1'b1;
            sda_pend <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            ack_seen <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ISR_M_IDLE: begin
                    if (cmd_valid) begin
                        op <= cmd;
                        sh <= cmd == ISR_CMD_READ ? 8'hff : wdata;
                        step <= 6'h00;
                        tick <= 16'h0000;
                        state <= ISR_M_BUSY;
                    end
                end
                ISR_M_BUSY: begin
                    // data moves half a step after the clock fell, never with it
                    if (sda_pend && tick == 16'(ISR_HALF_CYC / 2)) begin
                        sda_q <= sda_next;
                        sda_pend <= 1'b0;
                    end
                    if (tick != 16'(ISR_HALF_CYC - 1)) begin
                        tick <= tick + 16'h0001;
                    end else begin
                        tick <= 16'h0000;
                        step <= step + 6'h01;
                        if (op == ISR_CMD_START) begin
                            // bus assumed idle on entry
                            if (step == 6'h00) begin
                                sda_q <= 1'b1;
                                scl_q <= 1'b1;
                            end else if (step == 6'h01) begin
                                sda_q <= 1'b0;
                            end else begin
                                scl_q <= 1'b0;
                            end
                        end else if (op == ISR_CMD_STOP) begin
                            if (step == 6'h00) begin
                                sda_q <= 1'b0;
                            end else if (step == 6'h01) begin
                                scl_q <= 1'b1;
                            end else begin
                                sda_q <= 1'b1;
                            end
                        end else if (!step[0]) begin
                            // data changes only while clock low
                            if (step < 6'h10) begin
                                sda_next <= sh[7];
                            end else if (op == ISR_CMD_READ) begin
                                sda_next <= !rd_ack;
                            end else begin
                                sda_next <= 1'b1;
                            end
                            sda_pend <= step != 6'h12;
                            if (step != 6'h12) begin
                                scl_q <= 1'b0;
                            end
                        end else begin
                            scl_q <= 1'b1;
                            if (step < 6'h10) begin
                                sh <= {sh[6:0], 1'b0};
                                rdata <= {rdata[6:0], sda_s};
                            end else begin
                                ack_seen <= !sda_s;
                            end
                        end
                        if (step == last_step) begin
                            if (op != ISR_CMD_START && op != ISR_CMD_STOP) begin
                                scl_q <= 1'b0;
                            end
                            state <= ISR_M_IDLE;
                            done <= 1'b1;
                        end
                    end
                end
                default: state <= ISR_M_IDLE;
            endcase
        end
    end
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = !scl_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = !sda_q;
endmodule : isr_master

// file: testbench/isr_chk_sva.sv
// checker for the two wire link between the ram end and the master end
// assumes both wires are sampled on clk and idle high through pull-ups
module isr_chk
    import isr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // frame tracking
    logic p_scl, p_sda, in_frame, first, wr_mode, rd_mode, nacked, seen;
    logic [3:0] bit_n, cur;
    logic [7:0] shift;
    logic [15:0] per;
    wire rise = scl && !p_scl;
    wire start = scl && p_scl && p_sda && !sda;
    wire stop = scl && p_scl && !p_sda && sda;
    wire ninth = rise && in_frame && bit_n == 4'h8;
    always_ff @(posedge clk) begin
        p_scl <= scl;
        p_sda <= sda;
    end
    always_ff @(posedge clk) begin
        if (rst || stop || start) begin
            in_frame <= start && !rst;
            first <= start && !rst;
            wr_mode <= 1'b0;
            rd_mode <= 1'b0;
            nacked <= 1'b0;
            bit_n <= 4'h0;
            cur <= 4'hf;
        end else if (rise && in_frame) begin
            cur <= bit_n;
            bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
            if (bit_n != 4'h8) shift <= {shift[6:0], sda};
            if (bit_n == 4'h8 && first) begin
                first <= 1'b0;
                wr_mode <= !sda && !shift[0];
                rd_mode <= !sda && shift[0];
            end
            if (bit_n == 4'h8 && rd_mode && sda) nacked <= 1'b1;
        end
    end
    // period counter saturates at 16'hffff so slow gaps between frames never wrap
    always_ff @(posedge clk) begin
        if (rst) begin
            per <= 16'h0;
            seen <= 1'b0;
        end else if (rise) begin
            per <= 16'h0;
            seen <= 1'b1;
        end else if (per != 16'hffff) begin
            per <= per + 16'h1;
        end
    end
    // ==========================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_idle_released: assert property (!in_frame |-> !sda_s_oe)
        else $error("ram drives data outside a frame");
    chk_ram_change_low: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("ram changed data while clock high");
    chk_group_nomatch: assert property (ninth && first && shift[7:4] != ISR_GROUP |-> sda)
        else $error("ram acknowledged a foreign address");
    chk_write_ack: assert property (ninth && !first && wr_mode |-> !sda)
        else $error("written byte not acknowledged");
    chk_ack_held: assert property (scl && !rise && cur == 4'h8 && !p_sda |-> !sda)
        else $error("acknowledge not held through clock high");
    chk_tx_release: assert property (ninth && rd_mode |-> !sda_s_oe)
        else $error("ram drives data in read acknowledge slot");
    chk_nack_release: assert property (nacked |-> !sda_s_oe)
        else $error("ram drives data after missing acknowledge");
    chk_clock_period: assert property (rise && seen |-> per >= 16'(2 * ISR_HALF_CYC - 1))
        else $error("serial clock period too short");
    cover property (ninth && wr_mode && !sda);
    cover property (nacked);
    cover property (ninth && first && sda);
endmodule : isr_chk

// file: testbench/i2c_serial_ram_128x8_bench.sv
// bench: master end and ram end joined on one link, driven through master commands
// assumes package, interface and design compiled first; inputs change on falling edges
module i2c_serial_ram_128x8_bench
    import isr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, cmd_valid, rd_ack, test_pin, cmd_ready, done, ack_seen, power_save;
    logic [2:0] strap;
    isr_cmd_e cmd;
    logic [7:0] wdata, rdata, seed;
    logic [6:0] word_addr, ptr, base;
    logic [7:0] mem [128];
    int err_count, n_compared;
    isr_if bus ();
    isr_ram isr_ram_inst (.clk(clk), .rst(rst), .bus(bus), .slave_addr_strap_bit0(strap[0]),
        .slave_addr_strap_bit1(strap[1]), .slave_addr_strap_bit2(strap[2]),
        .test_pin(test_pin), .power_save(power_save), .word_addr(word_addr));
    isr_master isr_master_inst (.clk(clk), .rst(rst), .bus(bus), .cmd_valid(cmd_valid),
        .cmd(cmd), .wdata(wdata), .rd_ack(rd_ack), .cmd_ready(cmd_ready), .done(done),
        .rdata(rdata), .ack_seen(ack_seen));
    isr_chk isr_chk_inst (.clk(clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
        .sda_s_oe(bus.sda_s_oe));
    // ==========================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic stop_test();
        $display("errors %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic do_cmd(input isr_cmd_e c, input logic [7:0] d, input logic a);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = c;
        wdata = d;
        rd_ack = a;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (cmd_ready !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t command never taken", $time);
            stop_test();
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t command never completed", $time);
            stop_test();
        end
    endtask : do_cmd
    task automatic open_frame(input logic [2:0] s, input logic rd, input logic ack);
        do_cmd(ISR_CMD_START, 8'h00, 1'b0);
        do_cmd(ISR_CMD_WRITE, {ISR_GROUP, s, rd}, 1'b0);
        check_val({7'h00, ack_seen}, {7'h00, ack});
    endtask : open_frame
    task automatic write_frame(input logic [6:0] a, input int n);
        open_frame(strap, 1'b0, 1'b1);
        do_cmd(ISR_CMD_WRITE, {1'b0, a}, 1'b0);
        ptr = a;
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            mem[ptr] = seed;
            do_cmd(ISR_CMD_WRITE, seed, 1'b0);
            check_val({7'h00, ack_seen}, 8'h01);
            ptr = ptr + 7'h01;
        end
        do_cmd(ISR_CMD_STOP, 8'h00, 1'b0);
        check_val({1'b0, word_addr}, {1'b0, ptr});
    endtask : write_frame
    task automatic read_frame(input int n);
        open_frame(strap, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            do_cmd(ISR_CMD_READ, 8'h00, i != n - 1);
            check_val(rdata, mem[ptr]);
            ptr = ptr + 7'h01;
        end
        do_cmd(ISR_CMD_STOP, 8'h00, 1'b0);
        check_val({1'b0, word_addr}, {1'b0, ptr});
    endtask : read_frame
    // ==========================================
    // sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = ISR_CMD_START;
        wdata = 8'h00;
        rd_ack = 1'b0;
        test_pin = 1'b0;
        strap = 3'h5;
        seed = 8'h45;
        err_count = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check_val({1'b0, word_addr}, 8'h00);
        // first pass runs across the top of the store
        for (int k = 0; k < 2; k++) begin
            base = (k == 0) ? 7'h7e : seed[6:0];
            write_frame(base, 4);
            write_frame(base, 0);
            read_frame(4);
        end
        do_cmd(ISR_CMD_START, 8'h00, 1'b0);
        do_cmd(ISR_CMD_WRITE, {4'h5, strap, 1'b0}, 1'b0);
        check_val({7'h00, ack_seen}, 8'h00);
        do_cmd(ISR_CMD_WRITE, 8'h10, 1'b0);
        do_cmd(ISR_CMD_STOP, 8'h00, 1'b0);
        check_val({1'b0, word_addr}, {1'b0, ptr});
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            strap = i[2:0];
            repeat (4) @(negedge clk);
            open_frame(i[2:0] ^ (i[0] ? 3'h0 : 3'h6), 1'b0, i[0]);
            do_cmd(ISR_CMD_STOP, 8'h00, 1'b0);
        end
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            test_pin = (i != 8);
            strap = (i == 8) ? 3'h7 : i[2:0];
            repeat (4) @(negedge clk);
            check_val({7'h00, power_save}, {7'h00, i == 7});
        end
        stop_test();
    end
endmodule : i2c_serial_ram_128x8_bench
